// ---- src/upc_map.vh ----
`ifndef UPC_MAP_VH
`define UPC_MAP_VH
// Command codes
`define UPC_CMD_USER        8'hd1
`define UPC_CMD_GAIN        8'hd2
`define UPC_CMD_RAIL        8'hd3
// Reset values
`define UPC_USER_RST        16'h0402
`define UPC_GAIN_RST        16'hc200
// Writable bit masks; clear bits are unused and read zero
`define UPC_USER_MASK       16'hfc97
`define UPC_GAIN_MASK       16'hffff
`define UPC_RAIL_MASK       16'hff07
// User feature fields
`define UPC_MIND_HI         15
`define UPC_MIND_LO         11
`define UPC_DRV_STYLE       10
`define UPC_MIND_EN         7
`define UPC_MARGIN_EN       4
`define UPC_PG_PUSH         2
`define UPC_XT_EN           1
`define UPC_XT_FAULT        0
// Rail phase fields
`define UPC_PID_HI          15
`define UPC_PID_LO          13
`define UPC_RID_HI          12
`define UPC_RID_LO          8
`define UPC_CNT_HI          2
`define UPC_CNT_LO          0
// Phase count codes
`define UPC_CNT_2PH         3'h1
`define UPC_CNT_4PH         3'h3
// Slot constants
`define UPC_SLOT_HALF       3'h4
`define UPC_SLOT_ZERO       3'h0
// Minimum duty: 2*(v+1)/512 in units of 1/512
`define UPC_DUTY_W          9
`endif

// ---- src/upc_slot_calc.v ----
`timescale 1ns/1ps
// Phase slot placement in eighths of the switching period
module upc_slot_calc (
	shared,
	phase_idx,
	cnt_code,
	spread_slot,
	slot0,
	slot1
);
`include "upc_map.vh"
	input  wire       shared;
	input  wire [2:0] phase_idx;
	input  wire [2:0] cnt_code;
	input  wire [2:0] spread_slot;
	output reg  [2:0] slot0;
	output reg  [2:0] slot1;

	always @* begin
		if (!shared) begin
			// Alone: spread setting picks the first slot
			slot0 = spread_slot; // [R15] [R16]
			slot1 = spread_slot + `UPC_SLOT_HALF; // [R15]
		end else if (cnt_code == `UPC_CNT_4PH) begin
			slot0 = {phase_idx[1:0], 1'b0}; // [R14]
			slot1 = {phase_idx[1:0], 1'b0} + `UPC_SLOT_HALF; // [R14]
		end else begin
			slot0 = {1'b0, phase_idx[1:0]}; // [R14] [R16]
			slot1 = {1'b0, phase_idx[1:0]} + `UPC_SLOT_HALF; // [R14]
		end
	end
endmodule // upc_slot_calc

// ---- src/upc_duty_clamp.v ----
`timescale 1ns/1ps
// Minimum duty clamp on a 9-bit duty in 1/512 steps
module upc_duty_clamp (
	enable,
	min_field,
	duty_in,
	duty_out
);
`include "upc_map.vh"
	input  wire                   enable;
	input  wire [4:0]             min_field;
	input  wire [`UPC_DUTY_W-1:0] duty_in;
	output wire [`UPC_DUTY_W-1:0] duty_out;

	wire [`UPC_DUTY_W-1:0] floor_val;

	assign floor_val = {3'h0, min_field, 1'b0} + 9'h002; // [R1]
	// Bypassed when disabled, whatever the field holds
	assign duty_out = (enable && duty_in < floor_val) ?
		floor_val : duty_in; // [R1] [R2]
endmodule // upc_duty_clamp

// ---- src/upc_cfg_regs.v ----
`timescale 1ns/1ps
// Function
// R1: Minimum duty field bits 15:11 clamps duty to at least 2*(v+1)/512.
// R2: Clamp applies only while user bit 7 is set.
// R3: Bit 10 switches drive outputs between direct and power stage style.
// R4: Bit 4 derives margin voltages from the margin percentage setting.
// R5: Bit 2 picks power-good open-drain at 0, push-pull at 1.
// R6: External temperature measurement enabled only while bit 1 set.
// R7: Bit 0 selects external sensor for temperature fault judgement.
// R8: User register two bytes, read/write, protectable, resets to 0402h.
// R9: Sense gain register linear-11 milliohms, resets to C200h.
// R10: Phase config bits 15:13 hold phase position, valid 0 to 3.
// R11: Bits 12:8 hold rail id; equal ids share current.
// R12: Bits 2:0 hold phase count minus one; host writes 1,3,5,7.
// R13: At reset rail id takes strapped address low bits, rest zero.
// R14: Shared rail slots: index,index+4; 4-phase: 2*index,2*index+4.
// R15: Standalone device uses slots 0 and 4 automatically; code places it at spread_slot and spread_slot+4.
// R16: Spread setting affects only non-shared rails.
// R17: Unused bits ignore writes and read zero.
module upc_cfg_regs (
	sys_clk,
	rstn,
	cmd_code,
	wr_en,
	wr_data,
	write_protect,
	rd_data,
	cmd_hit,
	strap_addr,
	spread_slot,
	duty_req,
	duty_cmd,
	drive_pulse,
	drive_lo,
	low_side_drive_out,
	high_side_drive_out,
	pg_level,
	power_good_out,
	power_good_oe,
	margin_from_ratio,
	external_temp_sensor_en,
	temp_fault_ext_sel,
	sense_gain_exp,
	sense_gain_mant,
	rail_id,
	phase_idx,
	phase_cnt_code,
	rail_shared,
	slot0,
	slot1
);
`include "upc_map.vh"
	input  wire                   sys_clk;
	input  wire                   rstn;
	input  wire [7:0]             cmd_code;
	input  wire                   wr_en;
	input  wire [15:0]            wr_data;
	input  wire                   write_protect;
	output reg  [15:0]            rd_data;
	output wire                   cmd_hit;
	input  wire [6:0]             strap_addr;
	input  wire [2:0]             spread_slot;
	input  wire [`UPC_DUTY_W-1:0] duty_req;
	output reg  [`UPC_DUTY_W-1:0] duty_cmd;
	input  wire                   drive_pulse;
	input  wire                   drive_lo;
	output reg                    low_side_drive_out;
	output reg                    high_side_drive_out;
	input  wire                   pg_level;
	output reg                    power_good_out;
	output reg                    power_good_oe;
	output wire                   margin_from_ratio;
	output wire                   external_temp_sensor_en;
	output wire                   temp_fault_ext_sel;
	output wire [4:0]             sense_gain_exp;
	output wire [10:0]            sense_gain_mant;
	output wire [4:0]             rail_id;
	output wire [2:0]             phase_idx;
	output wire [2:0]             phase_cnt_code;
	output wire                   rail_shared;
	output reg  [2:0]             slot0;
	output reg  [2:0]             slot1;

	reg  [15:0]            user_feature_config_r;
	reg  [15:0]            input_current_sense_gain_r;
	reg  [15:0]            rail_phase_config_r;
	reg                    strap_load_r;
	wire [`UPC_DUTY_W-1:0] duty_clamped;
	wire [2:0]             slot0_nxt;
	wire [2:0]             slot1_nxt;
	wire                   wr_ok;

	function [15:0] upc_merge;
		input [15:0] old_v;
		input [15:0] new_v;
		input [15:0] mask;
		begin
			upc_merge = (new_v & mask) | (old_v & ~mask);
		end
	endfunction

	assign cmd_hit = (cmd_code == `UPC_CMD_USER) ||
		(cmd_code == `UPC_CMD_GAIN) || (cmd_code == `UPC_CMD_RAIL);
	// Protection blocks writes, reads still served
	assign wr_ok = wr_en && !write_protect; // [R8]

	always @(posedge sys_clk) begin
		if (!rstn) begin
			user_feature_config_r      <= `UPC_USER_RST; // [R8]
			input_current_sense_gain_r <= `UPC_GAIN_RST; // [R9]
			rail_phase_config_r        <= 16'h0000; // [R13]
			strap_load_r               <= 1'b1;
		end else begin
			strap_load_r <= 1'b0;
			// Strap caught after release, never under reset
			if (strap_load_r)
				rail_phase_config_r <= {3'h0, strap_addr[4:0],
					8'h00}; // [R13]
			else if (wr_ok && cmd_code == `UPC_CMD_RAIL)
				rail_phase_config_r <= upc_merge(rail_phase_config_r,
					wr_data, `UPC_RAIL_MASK) &
					`UPC_RAIL_MASK; // [R10] [R11] [R12] [R17]
			if (wr_ok && cmd_code == `UPC_CMD_USER)
				user_feature_config_r <= wr_data &
					`UPC_USER_MASK; // [R8] [R17]
			if (wr_ok && cmd_code == `UPC_CMD_GAIN)
				input_current_sense_gain_r <= wr_data &
					`UPC_GAIN_MASK; // [R9]
		end
	end

	always @* begin
		case (cmd_code)
		`UPC_CMD_USER: rd_data = user_feature_config_r;
		`UPC_CMD_GAIN: rd_data = input_current_sense_gain_r;
		`UPC_CMD_RAIL: rd_data = rail_phase_config_r;
		default:       rd_data = 16'h0000;
		endcase
	end

	assign margin_from_ratio       = user_feature_config_r[`UPC_MARGIN_EN]; // [R4]
	assign external_temp_sensor_en = user_feature_config_r[`UPC_XT_EN]; // [R6]
	// Fault source follows bit 0 only; measurement gating is separate
	assign temp_fault_ext_sel      = user_feature_config_r[`UPC_XT_FAULT]; // [R7]
	assign sense_gain_exp  = input_current_sense_gain_r[15:11]; // [R9]
	assign sense_gain_mant = input_current_sense_gain_r[10:0]; // [R9]
	assign rail_id        = rail_phase_config_r[`UPC_RID_HI:`UPC_RID_LO]; // [R11]
	assign phase_idx      = rail_phase_config_r[`UPC_PID_HI:`UPC_PID_LO]; // [R10]
	assign phase_cnt_code = rail_phase_config_r[`UPC_CNT_HI:`UPC_CNT_LO]; // [R12]
	// Counts of 2 phases or less mean a standalone device
	assign rail_shared = phase_cnt_code > `UPC_CNT_2PH; // [R14] [R15]

	upc_duty_clamp u_clamp (
		.enable    (user_feature_config_r[`UPC_MIND_EN]),
		.min_field (user_feature_config_r[`UPC_MIND_HI:`UPC_MIND_LO]),
		.duty_in   (duty_req),
		.duty_out  (duty_clamped)
	);

	upc_slot_calc u_slot (
		.shared      (rail_shared),
		.phase_idx   (phase_idx),
		.cnt_code    (phase_cnt_code),
		.spread_slot (spread_slot),
		.slot0       (slot0_nxt),
		.slot1       (slot1_nxt)
	);

	always @(posedge sys_clk) begin
		if (!rstn) begin
			duty_cmd            <= {`UPC_DUTY_W{1'b0}};
			slot0               <= `UPC_SLOT_ZERO;
			slot1               <= `UPC_SLOT_HALF;
			low_side_drive_out  <= 1'b0;
			high_side_drive_out <= 1'b0;
			power_good_out      <= 1'b0;
			power_good_oe       <= 1'b1;
		end else begin
			duty_cmd <= duty_clamped; // [R1] [R2]
			slot0    <= slot0_nxt; // [R14]
			slot1    <= slot1_nxt; // [R14]
			if (user_feature_config_r[`UPC_DRV_STYLE]) begin
				// Stage enable high unless drive_lo is set without drive_pulse
				low_side_drive_out  <= !drive_lo || drive_pulse; // [R3]
				high_side_drive_out <= drive_pulse; // [R3]
			end else begin
				low_side_drive_out  <= drive_lo; // [R3]
				high_side_drive_out <= drive_pulse; // [R3]
			end
			// Open-drain only drives low, releases for high
			power_good_out <= pg_level; // [R5]
			power_good_oe  <= user_feature_config_r[`UPC_PG_PUSH] ||
				!pg_level; // [R5]
		end
	end
endmodule // upc_cfg_regs

// ---- dv/upc_cfg_regs_props.sv ----
`timescale 1ns/1ps
`include "upc_map.vh"
module upc_cfg_regs_props (
	input wire                   sys_clk,
	input wire                   rstn,
	input wire [7:0]             cmd_code,
	input wire                   wr_en,
	input wire [15:0]            wr_data,
	input wire                   write_protect,
	input wire [15:0]            rd_data,
	input wire                   cmd_hit,
	input wire [`UPC_DUTY_W-1:0] duty_req,
	input wire [`UPC_DUTY_W-1:0] duty_cmd,
	input wire                   pg_level,
	input wire                   power_good_out,
	input wire                   power_good_oe,
	input wire [2:0]             slot0,
	input wire [2:0]             slot1
);
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rstn);
	chk_user_write: assert property ((wr_en && !write_protect &&
		cmd_code == 8'hd1) ##1 cmd_code == 8'hd1 |-> rd_data ==
		($past(wr_data) & `UPC_USER_MASK)) else $error("user write lost");
	chk_protect_hold: assert property ((write_protect &&
		cmd_code == 8'hd2) ##1 cmd_code == 8'hd2 |-> $stable(rd_data))
		else $error("protected write landed");
	chk_unknown_zero: assert property (!cmd_hit |-> rd_data == 16'h0000)
		else $error("unknown code reads nonzero");
	chk_hit_decode: assert property (cmd_hit == (cmd_code >= 8'hd1 &&
		cmd_code <= 8'hd3)) else $error("code decode wrong");
	chk_pg_follow: assert property (1 |=> power_good_out ==
		$past(pg_level)) else $error("power good level lost");
	chk_pg_low_drive: assert property (!pg_level |=> power_good_oe)
		else $error("power good low not driven");
	chk_duty_floor: assert property (1 |=> duty_cmd >=
		$past(duty_req)) else $error("duty cut below request");
	chk_slot_gap: assert property (slot1 == slot0 + 3'h4)
		else $error("second slot not half period away");
	cover property (wr_en && write_protect);
	cover property (duty_cmd > duty_req);
	cover property (slot0 != 3'h0);
endmodule // upc_cfg_regs_props
bind upc_cfg_regs upc_cfg_regs_props chk (.sys_clk, .rstn, .cmd_code, .wr_en,
	.wr_data, .write_protect, .rd_data, .cmd_hit, .duty_req, .duty_cmd,
	.pg_level, .power_good_out, .power_good_oe, .slot0, .slot1);

// ---- dv/upc_host_model.sv ----
`timescale 1ns/1ps
module upc_host_model (
	input  wire        sys_clk,
	input  wire [15:0] rd_data,
	output reg  [7:0]  cmd_code = 8'h00,
	output reg         wr_en = 1'b0,
	output reg  [15:0] wr_data = 16'h0000
);
	task wr(input [7:0] c, input [15:0] d);
		begin
			@(posedge sys_clk);
			cmd_code <= c;
			wr_data <= d;
			wr_en <= 1'b1;
			@(posedge sys_clk);
			wr_en <= 1'b0;
			wr_data <= ~d; // Idle bus must not echo the last word
		end
	endtask
	task rd(input [7:0] c, output [15:0] d);
		begin
			@(posedge sys_clk);
			cmd_code <= c;
			@(posedge sys_clk);
			d = rd_data;
		end
	endtask
endmodule // upc_host_model

// ---- dv/test_upc_cfg_regs.sv ----
`timescale 1ns/1ps
`include "upc_map.vh"
module test_upc_cfg_regs;
	reg                    sys_clk = 1'b0;
	reg                    rstn = 1'b0;
	reg                    write_protect = 1'b0;
	reg  [6:0]             strap_addr = 7'h5a;
	reg  [2:0]             spread_slot = 3'h0;
	reg  [`UPC_DUTY_W-1:0] duty_req = 9'h000;
	reg                    pg_level = 1'b1;
	reg                    drive_pulse = 1'b0;
	reg                    drive_lo = 1'b0;
	wire                   lo_out;
	wire                   hi_out;
	wire                   margin;
	wire [4:0]             g_exp;
	wire [10:0]            g_mant;
	wire [2:0]             cnt;
	wire                   shared;
	wire [7:0]             cmd_code;
	wire                   wr_en;
	wire [15:0]            wr_data;
	wire [15:0]            rd_data;
	wire [`UPC_DUTY_W-1:0] duty_cmd;
	wire                   pg_oe;
	wire                   xt_en;
	wire                   xt_flt;
	wire [4:0]             rail_id;
	wire [2:0]             p_idx;
	wire [2:0]             slot0;
	wire [2:0]             slot1;
	integer                errors = 0;
	integer                checked = 0;
	integer                cyc = 0;
	integer                i;
	integer                k;
	reg  [15:0]            v;
	reg  [2:0]             e;
	always #20 sys_clk = ~sys_clk;
	upc_host_model host (.sys_clk(sys_clk), .rd_data(rd_data),
		.cmd_code(cmd_code), .wr_en(wr_en), .wr_data(wr_data));
	upc_cfg_regs dut (.sys_clk(sys_clk), .rstn(rstn), .cmd_code(cmd_code),
		.wr_en(wr_en), .wr_data(wr_data), .write_protect(write_protect),
		.rd_data(rd_data), .cmd_hit(), .strap_addr(strap_addr),
		.spread_slot(spread_slot), .duty_req(duty_req), .duty_cmd(duty_cmd),
		.drive_pulse(drive_pulse), .drive_lo(drive_lo),
		.low_side_drive_out(lo_out), .high_side_drive_out(hi_out),
		.pg_level(pg_level), .power_good_out(),
		.power_good_oe(pg_oe), .margin_from_ratio(margin),
		.external_temp_sensor_en(xt_en), .temp_fault_ext_sel(xt_flt),
		.sense_gain_exp(g_exp), .sense_gain_mant(g_mant), .rail_id(rail_id),
		.phase_idx(p_idx), .phase_cnt_code(cnt), .rail_shared(shared),
		.slot0(slot0), .slot1(slot1));
	task chk(input [15:0] got, input [15:0] exp);
		begin
			checked = checked + 1;
			if (got !== exp) begin
				errors = errors + 1;
				$display("mismatch %0t got %h want %h", $time, got, exp);
			end
		end
	endtask
	task duty(input [8:0] r, input [8:0] x);
		begin
			@(posedge sys_clk);
			duty_req <= r;
			repeat (2) @(posedge sys_clk);
			chk({7'h00, duty_cmd}, {7'h00, x});
		end
	endtask
	task t_reset;
		begin
			host.rd(8'hd1, v); chk(v, 16'h0402);
			host.rd(8'hd2, v); chk(v, 16'hc200);
			host.rd(8'hd3, v); chk(v, {3'h0, strap_addr[4:0], 8'h00});
			chk({15'h0, xt_en}, 16'h1);
			chk({15'h0, xt_flt}, 16'h0);
			$display("reset test done");
		end
	endtask
	task t_mask;
		begin
			host.wr(8'hd1, 16'hffff); host.rd(8'hd1, v); chk(v, 16'hfc97);
			chk({15'h0, xt_flt}, 16'h1);
			chk({15'h0, margin}, 16'h1);
			host.wr(8'hd3, 16'hffff); host.rd(8'hd3, v); chk(v, 16'hff07);
			host.rd(8'hd0, v); chk(v, 16'h0000);
			host.wr(8'hd2, 16'h1234); host.rd(8'hd2, v); chk(v, 16'h1234);
			chk({11'h0, g_exp}, 16'h0002);
			chk({5'h0, g_mant}, 16'h0234);
			@(posedge sys_clk);
			write_protect <= 1'b1;
			host.wr(8'hd2, 16'h5678); host.rd(8'hd2, v); chk(v, 16'h1234);
			write_protect <= 1'b0;
			$display("mask test done");
		end
	endtask
	task t_duty;
		begin
			host.wr(8'hd1, 16'hf880);
			duty(9'd63, 9'd64); duty(9'd65, 9'd65);
			host.wr(8'hd1, 16'h0080);
			duty(9'd0, 9'd2);
			host.wr(8'hd1, 16'hf800);
			duty(9'd5, 9'd5);
			repeat (2) @(posedge sys_clk);
			chk({15'h0, pg_oe}, 16'h0);
			host.wr(8'hd1, 16'h0004);
			repeat (2) @(posedge sys_clk);
			chk({15'h0, pg_oe}, 16'h1);
			$display("duty test done");
		end
	endtask
	task t_slots;
		begin
			for (k = 1; k < 8; k = k + 2)
				for (i = 0; i < (k + 1) / 2; i = i + 1) begin
					spread_slot <= (k == 1) ? 3'h0 : 3'h5;
					host.wr(8'hd3, {i[2:0], 5'h07, 5'h00, k[2:0]});
					e = (k == 1) ? 3'h0 : (k == 3) ? 2 * i[2:0] : i[2:0];
					repeat (2) @(posedge sys_clk);
					chk({13'h0, slot0}, {13'h0, e});
					chk({13'h0, slot1}, {13'h0, e + 3'h4});
					chk({13'h0, p_idx}, {13'h0, i[2:0]});
					chk({11'h0, rail_id}, 16'h0007);
					chk({13'h0, cnt}, {13'h0, k[2:0]});
					chk({15'h0, shared}, {15'h0, k != 1});
				end
			// Standalone follows the spread setting
			spread_slot <= 3'h5;
			host.wr(8'hd3, {3'h0, 5'h07, 5'h00, 3'h1});
			repeat (2) @(posedge sys_clk);
			chk({13'h0, slot0}, 16'h0005);
			chk({13'h0, slot1}, 16'h0001);
			$display("slot test done");
		end
	endtask
	task t_drive;
		begin
			host.wr(8'hd1, 16'h0004);
			drive_lo <= 1'b1;
			drive_pulse <= 1'b0;
			repeat (2) @(posedge sys_clk);
			chk({15'h0, margin}, 16'h0);
			chk({14'h0, lo_out, hi_out}, 16'h0002);
			host.wr(8'hd1, 16'h0404);
			repeat (2) @(posedge sys_clk);
			chk({14'h0, lo_out, hi_out}, 16'h0000);
			drive_lo <= 1'b0;
			drive_pulse <= 1'b1;
			repeat (2) @(posedge sys_clk);
			chk({14'h0, lo_out, hi_out}, 16'h0003);
			drive_pulse <= 1'b0;
			repeat (2) @(posedge sys_clk);
			chk({14'h0, lo_out, hi_out}, 16'h0002);
			$display("drive test done");
		end
	endtask
	task test_done;
		begin
			$display("checks %0d mismatches %0d", checked, errors);
			if (errors == 0 && checked > 0)
				$display("verification passed");
			else
				$display("verification failed");
			$finish;
		end
	endtask
	always @(posedge sys_clk) begin
		cyc = cyc + 1;
		if (cyc == 3000) begin
			errors = errors + 1;
			test_done;
		end
	end
	initial begin
		repeat (8) @(posedge sys_clk);
		rstn <= 1'b1;
		repeat (2) @(posedge sys_clk);
		t_reset;
		t_mask;
		t_duty;
		t_drive;
		t_slots;
		test_done;
	end
endmodule // test_upc_cfg_regs
